//--- ckfp_clock_ctrl.v
// Purpose: Clock control, calibration and fire pulses over AHB-Lite.
// Assumes: hclk 10 MHz; ref_clk_in and hs_clk_in asynchronous pins.
// Notes:   Calibration fraction comes from hclk phase sampling.
//
// Notes on behaviour
// R1 - Oscillator runs from reset onward
// R2 - Delay codes above 1 power oscillator per command
// R3 - Settling delay chosen by start delay code
// R4 - Code 1 means always on, no delay
// R5 - Measurement waits until delay fully elapsed
// R6 - Delays and calibration timed by reference clock
// R7 - Test pin 1 carries reference clock at code 3
// R8 - Test pin 2 carries reference over eight
// R9 - Calibration measures, stores result, raises interrupt
// R10 - Calibration window is eight reference periods
// R11 - Result is 16.16 fixed point hs periods
// R12 - Host applies one coefficient to both directions
// R13 - Fire burst of 1 to 127, zero disables
// R14 - Each fire output may float on its own
// R15 - Idle fire outputs float or drive ground
// R16 - Fire pulse may start the time unit
// R17 - Fire base clock is prescaled hs clock
// R18 - Doubled base clock divided by code plus one
// R19 - Driver bits: complement, enable a, enable b
// R20 - Completion shown by falling edge on irq_n
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "ckfp_defines.vh"
module ckfp_clock_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire ref_clk_in,
  input wire hs_clk_in,
  input wire meas_done,
  output reg hs_osc_en,
  output reg meas_start,
  output reg [2:0] meas_cmd,
  output reg test_out_pin1,
  output reg test_out_pin2,
  output reg irq_n,
  output wire fire_out_a,
  output wire fire_out_a_oe_n,
  output wire fire_out_b,
  output wire fire_out_b_oe_n,
  output wire tdc_start
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_OSC_WAIT = 3'd1;
  localparam [2:0] S_MEAS = 3'd2;
  localparam [2:0] S_CAL_ARM = 3'd3;
  localparam [2:0] S_CAL_RUN = 3'd4;

  // Register index decode, shared by the read and the write path
  function [2:0] reg_index;
    input [31:0] a;
    begin
      case (a[7:0])
        `CKFP_OFS_CLK_CFG: reg_index = 3'd1;
        `CKFP_OFS_FIRE_CFG: reg_index = 3'd2;
        `CKFP_OFS_CMD: reg_index = 3'd3;
        `CKFP_OFS_STATUS: reg_index = 3'd4;
        `CKFP_OFS_CALIB: reg_index = 3'd5;
        default: reg_index = 3'd0;
      endcase
      if (a[31:8] != 24'h0 || a[1:0] != 2'b00) begin
        reg_index = 3'd0;
      end
    end
  endfunction

  // Start delay in reference periods for a delay code
  function [7:0] dly_target;
    input [2:0] code;
    integer t;
    begin
      case (code)
        3'd2: t = `CKFP_REF_CYC(`CKFP_DLY_480US_NS);
        3'd3: t = `CKFP_REF_CYC(`CKFP_DLY_1460US_NS);
        3'd4: t = `CKFP_REF_CYC(`CKFP_DLY_2440US_NS);
        default: t = `CKFP_REF_CYC(`CKFP_DLY_5140US_NS);
      endcase
      dly_target = t[7:0];
    end
  endfunction
  // ----------------------------------------------------------------
  // Configuration and state
  // ----------------------------------------------------------------
  reg [2:0] dly_sel;
  reg [1:0] tst1_sel;
  reg [1:0] tst2_sel;
  reg [1:0] prediv;
  reg [6:0] fire_pulse_count;
  reg fire_idle_state;
  reg fire_to_tdc_start_sel;
  reg [5:0] fire_clk_div;
  reg [2:0] fire_driver_cfg;
  reg [31:0] calib_result;
  reg [2:0] state;
  reg [7:0] dly_cnt;
  reg [3:0] cal_edges;
  reg [15:0] hs_cnt;
  reg [15:0] hs_period;
  reg [15:0] since_hs;
  reg fire_go;
  reg wr_pend;
  reg [2:0] wr_idx;
  reg [1:0] ref_sync;
  reg [1:0] hs_sync;
  reg ref_prev;
  reg hs_prev;
  reg [2:0] ref_div;
  wire ref_rise;
  wire hs_rise;
  wire hs_edge;
  wire addr_ok;
  wire cmd_wr;
  wire fire_busy;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // Edges are taken from the second stage only, never the first
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_sync <= 2'b00;
      hs_sync <= 2'b00;
      ref_prev <= 1'b0;
      hs_prev <= 1'b0;
    end else begin
      ref_sync <= {ref_sync[0], ref_clk_in};
      hs_sync <= {hs_sync[0], hs_clk_in};
      ref_prev <= ref_sync[1];
      hs_prev <= hs_sync[1];
    end
  end

  assign ref_rise = ref_sync[1] && !ref_prev;
  assign hs_rise = hs_sync[1] && !hs_prev;
  assign hs_edge = hs_sync[1] != hs_prev;

  // Test pins; pin 2 toggles every fourth reference rise
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_div <= 3'h0;
      test_out_pin1 <= 1'b0;
      test_out_pin2 <= 1'b0;
    end else begin
      if (ref_rise) begin
        ref_div <= ref_div + 3'h1;
      end
      test_out_pin1 <= (tst1_sel == `CKFP_TST_CLK_CODE) && ref_sync[1]; // R7
      test_out_pin2 <= (tst2_sel == `CKFP_TST_CLK_CODE) && ref_div[2]; // R8
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign addr_ok = hsel && htrans[1] && hready;
  assign cmd_wr = wr_pend && (wr_idx == 3'd3);

  // Address phase capture; read data is prepared for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 3'd0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_ok && hwrite;
      wr_idx <= reg_index(haddr);
      if (addr_ok && !hwrite) begin
        case (reg_index(haddr))
          3'd1: hrdata <= {22'h0, prediv, tst2_sel, tst1_sel, 1'b0, dly_sel};
          3'd2: hrdata <= {fire_driver_cfg, 7'h0, fire_clk_div, 6'h0,
                           fire_to_tdc_start_sel, fire_idle_state, 1'b0,
                           fire_pulse_count};
          3'd3: hrdata <= {29'h0, meas_cmd};
          3'd4: hrdata <= {24'h0, fire_busy, !irq_n, hs_osc_en,
                           (state != S_IDLE), 1'b0, state};
          3'd5: hrdata <= calib_result; // R11
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Register writes in the data phase; unmapped writes are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_sel <= `CKFP_RST_DLY_SEL; // R1
      tst1_sel <= 2'h0;
      tst2_sel <= 2'h0;
      prediv <= 2'h0;
      fire_pulse_count <= 7'h0;
      fire_idle_state <= 1'b0;
      fire_to_tdc_start_sel <= 1'b0;
      fire_clk_div <= `CKFP_RST_FIRE_DIV;
      fire_driver_cfg <= 3'h0;
    end else if (wr_pend && wr_idx == 3'd1) begin
      dly_sel <= hwdata[`CKFP_CLK_DLY_LSB +: 3];
      tst1_sel <= hwdata[`CKFP_CLK_TST1_LSB +: 2];
      tst2_sel <= hwdata[`CKFP_CLK_TST2_LSB +: 2];
      prediv <= hwdata[`CKFP_CLK_PREDIV_LSB +: 2];
    end else if (wr_pend && wr_idx == 3'd2) begin
      fire_pulse_count <= hwdata[`CKFP_FIRE_CNT_LSB +: 7];
      fire_idle_state <= hwdata[`CKFP_FIRE_IDLE_BIT];
      fire_to_tdc_start_sel <= hwdata[`CKFP_FIRE_TDC_BIT];
      fire_clk_div <= hwdata[`CKFP_FIRE_DIV_LSB +: 6];
      fire_driver_cfg <= hwdata[`CKFP_FIRE_DRV_LSB +: 3]; // R19
    end
  end

  // ----------------------------------------------------------------
  // High-speed clock period tracking for the calibration fraction
  // ----------------------------------------------------------------
  // Fraction is hclk time past the last hs rise over one hs period
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_hs <= 16'h0;
      hs_period <= 16'h1;
    end else if (hs_rise) begin
      hs_period <= (since_hs == 16'h0) ? 16'h1 : since_hs + 16'h1;
      since_hs <= 16'h0;
    end else if (since_hs != 16'hffff) begin
      since_hs <= since_hs + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator gating, measurement start and calibration sequencer
  // ----------------------------------------------------------------
  // Commands are accepted only when idle, so the interrupt release on
  // acceptance can never meet a completion in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      hs_osc_en <= 1'b1; // R1
      meas_start <= 1'b0;
      meas_cmd <= 3'h0;
      irq_n <= 1'b1;
      dly_cnt <= 8'h0;
      cal_edges <= 4'h0;
      hs_cnt <= 16'h0;
      calib_result <= 32'h0;
      fire_go <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      fire_go <= 1'b0;
      case (state)
        S_IDLE: begin
          hs_osc_en <= (dly_sel == 3'd1); // R4
          if (cmd_wr && hwdata[2:0] == `CKFP_CMD_FIRE) begin
            fire_go <= 1'b1; // R13
          end else if (cmd_wr && hwdata[2:0] >= `CKFP_CMD_FLIGHT &&
                       hwdata[2:0] <= `CKFP_CMD_CALIB) begin
            meas_cmd <= hwdata[2:0];
            irq_n <= 1'b1;
            dly_cnt <= 8'h0;
            if (dly_sel > 3'd1) begin
              hs_osc_en <= 1'b1; // R2
              state <= S_OSC_WAIT; // R3
            end else if (hwdata[2:0] == `CKFP_CMD_CALIB) begin
              state <= S_CAL_ARM; // R4
            end else begin
              meas_start <= 1'b1; // R4
              state <= S_MEAS;
            end
          end
        end
        S_OSC_WAIT: begin
          if (ref_rise) begin
            dly_cnt <= dly_cnt + 8'h1; // R6
            if (dly_cnt + 8'h1 >= dly_target(dly_sel)) begin // R3 R5
              if (meas_cmd == `CKFP_CMD_CALIB) begin
                state <= S_CAL_ARM;
              end else begin
                meas_start <= 1'b1; // R5
                state <= S_MEAS;
              end
            end
          end
        end
        S_MEAS: begin
          if (meas_done) begin
            irq_n <= 1'b0; // R20
            hs_osc_en <= (dly_sel == 3'd1); // R2
            state <= S_IDLE;
          end
        end
        S_CAL_ARM: begin
          if (ref_rise) begin
            cal_edges <= 4'h0; // R9
            hs_cnt <= 16'h0;
            state <= S_CAL_RUN;
          end
        end
        S_CAL_RUN: begin
          if (hs_rise) begin
            hs_cnt <= hs_cnt + 16'h1;
          end
          if (ref_rise) begin
            cal_edges <= cal_edges + 4'h1; // R6
            if (cal_edges == 4'd`CKFP_CAL_PERIODS - 4'd1) begin // R10
              calib_result <= {hs_cnt + {15'h0, hs_rise}, // R11
                               frac_of(since_hs, hs_period)};
              irq_n <= 1'b0; // R9 R20
              hs_osc_en <= (dly_sel == 3'd1); // R2
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Fraction of an hs period: remainder scaled to 16 bits, saturating
  function [15:0] frac_of;
    input [15:0] part;
    input [15:0] whole;
    reg [31:0] q;
    begin
      q = ({part, 16'h0}) / {16'h0, whole};
      frac_of = (q[31:16] != 16'h0) ? 16'hffff : q[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Fire pulse generator
  // ----------------------------------------------------------------
  ckfp_fire_gen u_fire (
    .hclk(hclk),
    .hresetn(hresetn),
    .hs_edge(hs_edge),
    .start(fire_go),
    .pulse_count(fire_pulse_count),
    .idle_state(fire_idle_state),
    .to_tdc_sel(fire_to_tdc_start_sel),
    .clk_div(fire_clk_div),
    .prediv(prediv),
    .driver_cfg(fire_driver_cfg),
    .fire_out_a(fire_out_a),
    .fire_out_a_oe_n(fire_out_a_oe_n),
    .fire_out_b(fire_out_b),
    .fire_out_b_oe_n(fire_out_b_oe_n),
    .tdc_start(tdc_start),
    .busy(fire_busy)
  );

endmodule // ckfp_clock_ctrl

//--- ckfp_defines.vh
// Purpose: Register map, reset values and timing counts.
// Assumes: 32-bit AHB-Lite register bus, hclk at 10 MHz.
// Notes:   Definitions only.
`ifndef CKFP_DEFINES_VH
`define CKFP_DEFINES_VH

// --------------
// Register map
// --------------
`define CKFP_OFS_CLK_CFG 8'h00
`define CKFP_OFS_FIRE_CFG 8'h04
`define CKFP_OFS_CMD 8'h08
`define CKFP_OFS_STATUS 8'h0c
`define CKFP_OFS_CALIB 8'h10
`define CKFP_CLK_DLY_LSB 0
`define CKFP_CLK_TST1_LSB 4
`define CKFP_CLK_TST2_LSB 6
`define CKFP_CLK_PREDIV_LSB 8
`define CKFP_FIRE_CNT_LSB 0
`define CKFP_FIRE_IDLE_BIT 8
`define CKFP_FIRE_TDC_BIT 9
`define CKFP_FIRE_DIV_LSB 16
`define CKFP_FIRE_DRV_LSB 29

// --------------
// Reset values and command codes
// --------------
`define CKFP_RST_DLY_SEL 3'h1
`define CKFP_RST_FIRE_DIV 6'h01
`define CKFP_TST_CLK_CODE 2'h3
`define CKFP_CMD_FLIGHT 3'h1
`define CKFP_CMD_FLIGHT_PAIR 3'h2
`define CKFP_CMD_TEMP 3'h3
`define CKFP_CMD_TEMP_PAIR 3'h4
`define CKFP_CMD_CALIB 3'h5
`define CKFP_CMD_FIRE 3'h6

// --------------
// Timing, in nanoseconds and reference clock periods
// --------------
`define CKFP_REF_PERIOD_NS 30518
`define CKFP_DLY_480US_NS 480000
`define CKFP_DLY_1460US_NS 1460000
`define CKFP_DLY_2440US_NS 2440000
`define CKFP_DLY_5140US_NS 5140000
`define CKFP_REF_CYC(t) (((t) + `CKFP_REF_PERIOD_NS - 1) / `CKFP_REF_PERIOD_NS)
`define CKFP_CAL_PERIODS 8

`endif

//--- ckfp_fire_gen.v
// Purpose: Fire pulse burst generator with divider and output drivers.
// Assumes: hs_edge pulses once per sampled edge of the high-speed clock.
// Notes:   Pins are split into level and active-low output enable.
`timescale 1ns/1ps
module ckfp_fire_gen (
  input wire hclk,
  input wire hresetn,
  input wire hs_edge,
  input wire start,
  input wire [6:0] pulse_count,
  input wire idle_state,
  input wire to_tdc_sel,
  input wire [5:0] clk_div,
  input wire [1:0] prediv,
  input wire [2:0] driver_cfg,
  output reg fire_out_a,
  output reg fire_out_a_oe_n,
  output reg fire_out_b,
  output reg fire_out_b_oe_n,
  output reg tdc_start,
  output reg busy
);

  reg [2:0] pre_cnt;
  reg [5:0] div_cnt;
  reg [6:0] left;
  reg phase;
  wire base_tick;
  wire [2:0] pre_last;
  wire [5:0] half;

  // --------------
  // Base clock: both edges of hs give the doubled rate, then prediv
  // --------------
  assign pre_last = (3'h1 << prediv) - 3'h1;
  assign base_tick = hs_edge && (pre_cnt == pre_last); // R17 R18
  // Rounded-up half without the 6-bit overflow at code 63
  assign half = {1'b0, clk_div[5:1]} + {5'h0, clk_div[0]};

  // Burst sequencing; a divide code of 0 ends a pulse on every base tick, so phase stays high
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h0;
      left <= 7'h0;
      phase <= 1'b0;
      busy <= 1'b0;
      tdc_start <= 1'b0;
    end else begin
      tdc_start <= 1'b0;
      if (hs_edge) begin
        pre_cnt <= (pre_cnt == pre_last) ? 3'h0 : pre_cnt + 3'h1;
      end
      if (start && !busy && pulse_count != 7'h0) begin // R13
        busy <= 1'b1;
        left <= pulse_count;
        div_cnt <= 6'h0;
        phase <= 1'b1;
        tdc_start <= to_tdc_sel; // R16
      end else if (busy && base_tick) begin
        if (div_cnt >= clk_div) begin // R18
          div_cnt <= 6'h0;
          if (left == 7'h1) begin
            busy <= 1'b0;
            phase <= 1'b0;
          end else begin
            phase <= 1'b1;
          end
          left <= left - 7'h1;
        end else begin
          div_cnt <= div_cnt + 6'h1;
          phase <= (div_cnt + 6'h1) < half;
        end
      end
    end
  end

  // Output drivers: each pin can be left floating on its own
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fire_out_a <= 1'b0;
      fire_out_a_oe_n <= 1'b1;
      fire_out_b <= 1'b0;
      fire_out_b_oe_n <= 1'b1;
    end else if (busy) begin
      fire_out_a <= phase;
      fire_out_a_oe_n <= !driver_cfg[1]; // R14 R19
      fire_out_b <= driver_cfg[2] ? !phase : phase; // R19
      fire_out_b_oe_n <= !driver_cfg[0]; // R14 R19
    end else begin
      fire_out_a <= 1'b0;
      fire_out_a_oe_n <= !(idle_state && driver_cfg[1]); // R15
      fire_out_b <= 1'b0;
      fire_out_b_oe_n <= !(idle_state && driver_cfg[0]); // R15
    end
  end

endmodule // ckfp_fire_gen

//--- ckfp_clock_ctrl_sva.sv
// Purpose: Port assertions for the clock and fire pulse control block.
// Assumes: One clock, hclk; reset hresetn, asynchronous, active low.
// Notes:   Field shadows rebuilt from bus traffic.
`timescale 1ns/1ps
`include "ckfp_defines.vh"
module ckfp_clock_ctrl_sva (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire ref_clk_in,
  input wire meas_done,
  input wire hs_osc_en,
  input wire meas_start,
  input wire [2:0] meas_cmd,
  input wire test_out_pin1,
  input wire irq_n,
  input wire fire_out_a_oe_n,
  input wire tdc_start
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic dp_wr;
  logic [7:0] dp_adr;
  logic [2:0] dly;
  logic [1:0] ts1;
  logic fen_a;
  logic tdc_sel;
  logic [2:0] rs;
  logic [7:0] ref_cnt;
  logic [7:0] n_need;
  wire wr_end = dp_wr && hready;
  wire cmd_dp = wr_end && dp_adr == `CKFP_OFS_CMD;
  wire rref = rs[1] && !rs[2];

  // --------------
  // Shadows and reference edge count
  // --------------
  // Ref edges synced like the block's
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_adr <= 8'h00;
      dly <= `CKFP_RST_DLY_SEL;
      ts1 <= 2'h0;
      fen_a <= 1'b0;
      tdc_sel <= 1'b0;
      rs <= 3'h0;
      ref_cnt <= 8'h00;
    end else begin
      if (hready) begin
        dp_wr <= hsel && htrans[1] && hwrite;
        dp_adr <= haddr[7:0];
      end
      if (wr_end && dp_adr == `CKFP_OFS_CLK_CFG) begin
        dly <= hwdata[2:0];
        ts1 <= hwdata[5:4];
      end
      if (wr_end && dp_adr == `CKFP_OFS_FIRE_CFG) begin
        fen_a <= hwdata[30];
        tdc_sel <= hwdata[9];
      end
      rs <= {rs[1:0], ref_clk_in};
      ref_cnt <= cmd_dp ? 8'h00 : ref_cnt + {7'h0, rref};
    end
  end

  // Reference edges each delay code waits for
  always_comb begin
    case (dly)
      3'h2: n_need = 8'h10;
      3'h3: n_need = 8'h30;
      3'h4: n_need = 8'h50;
      default: n_need = 8'ha9;
    endcase
  end

  // --------------
  // Assertions
  // --------------
  sequence s_quiet;
    !irq_n && !cmd_dp ##1 !cmd_dp;
  endsequence
  sequence s_tdc;
    tdc_sel ##1 !tdc_start;
  endsequence

  AST_OSC_CONT: assert property (
    dly == 3'h1 && $past(dly) == 3'h1 |-> hs_osc_en)
    else $error("oscillator dropped while always on");
  AST_OSC_OFF: assert property (
    dly == 3'h0 && $past(dly) == 3'h0 |-> !hs_osc_en)
    else $error("oscillator on with code zero");
  AST_OSC_CMD: assert property (
    $rose(hs_osc_en) |-> $past(cmd_dp) || dly == 3'h1)
    else $error("oscillator started unasked");
  AST_DLY_WAIT: assert property (
    meas_start && dly > 3'h1 && meas_cmd != `CKFP_CMD_CALIB
    |-> ref_cnt == n_need)
    else $error("start before delay end");
  AST_CAL_WIN: assert property (
    $fell(irq_n) && meas_cmd == `CKFP_CMD_CALIB
    |-> ref_cnt == `CKFP_CAL_PERIODS + 1)
    else $error("calibration window length wrong");
  AST_IRQ_CAUSE: assert property (
    $fell(irq_n) |-> $past(meas_done) || meas_cmd == `CKFP_CMD_CALIB)
    else $error("completion flag without completion");
  AST_IRQ_HOLD: assert property (s_quiet |=> !irq_n)
    else $error("flag released early");
  AST_MEAS_PULSE: assert property (
    meas_start |-> (hs_osc_en || dly == 3'h0) ##1 !meas_start)
    else $error("bad start pulse");
  AST_TST1: assert property (
    ts1 != 2'h3 && $past(ts1) != 2'h3 |-> !test_out_pin1)
    else $error("test pin 1 active while not selected");
  AST_FIRE_HIZ_A: assert property (
    !fen_a && !$past(fen_a) |-> fire_out_a_oe_n)
    else $error("disabled fire output a driven");
  AST_TDC: assert property (tdc_start |-> s_tdc)
    else $error("time unit start pulse wrong");
endmodule // ckfp_clock_ctrl_sva

bind ckfp_clock_ctrl ckfp_clock_ctrl_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .ref_clk_in(ref_clk_in), .meas_done(meas_done), .hs_osc_en(hs_osc_en),
  .meas_start(meas_start), .meas_cmd(meas_cmd),
  .test_out_pin1(test_out_pin1), .irq_n(irq_n),
  .fire_out_a_oe_n(fire_out_a_oe_n), .tdc_start(tdc_start)
);

//--- ckfp_far_model.sv
// Purpose: Oscillators and measurement core beside the block.
// Assumes: Reference runs free; the fast clock only while powered.
// Notes:   Core answers fast and slow in turn.
`timescale 1ns/1ps
`include "ckfp_defines.vh"
module ckfp_far_model (
  input wire hclk,
  input wire hs_osc_en,
  input wire meas_start,
  output logic ref_clk_in,
  output logic hs_clk_in,
  output logic meas_done
);
  int n_meas;

  // Free-running reference oscillator
  initial begin
    ref_clk_in = 1'b0;
    forever #(`CKFP_REF_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;
  end

  // 4 MHz oscillator, silent when unpowered so gating faults show
  initial begin
    hs_clk_in = 1'b0;
    forever #125 hs_clk_in = hs_osc_en ? ~hs_clk_in : 1'b0;
  end

  // Measurement core: one done pulse per start
  initial begin
    n_meas = 0;
    meas_done = 1'b0;
    forever begin
      @(posedge hclk);
      if (meas_start === 1'b1) begin
        n_meas++;
        repeat (n_meas[0] ? 3 : 60) @(posedge hclk);
        meas_done <= 1'b1;
        @(posedge hclk);
        meas_done <= 1'b0;
      end
    end
  end
endmodule // ckfp_far_model

//--- ckfp_clock_ctrl_test.sv
// Purpose: Self-checking bench for the clock and fire control block.
// Assumes: hclk 10 MHz; bus master drives by non-blocking assignment.
// Notes:   Read expectations queue up; a monitor compares them.
`timescale 1ns/1ps
`include "ckfp_defines.vh"
module ckfp_clock_ctrl_test;
  logic hclk, hresetn, hsel, hwrite, rd_dp, cmp_on;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, seed, cnt, exp_q[$], msk_q[$];
  wire hready;
  wire [31:0] hrdata;
  wire ref_clk_in, hs_clk_in, meas_done, hs_osc_en, meas_start;
  wire [2:0] meas_cmd;
  wire test_out_pin1, test_out_pin2, irq_n, tdc_start;
  wire fire_out_a, fire_out_a_oe_n, fire_out_b, fire_out_b_oe_n;
  int mismatches, samples_checked, n_a, n_tdc, n_ref, n0, k, c, i;

  ckfp_clock_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(),
    .ref_clk_in(ref_clk_in), .hs_clk_in(hs_clk_in),
    .meas_done(meas_done), .hs_osc_en(hs_osc_en),
    .meas_start(meas_start), .meas_cmd(meas_cmd),
    .test_out_pin1(test_out_pin1), .test_out_pin2(test_out_pin2),
    .irq_n(irq_n), .fire_out_a(fire_out_a),
    .fire_out_a_oe_n(fire_out_a_oe_n), .fire_out_b(fire_out_b),
    .fire_out_b_oe_n(fire_out_b_oe_n), .tdc_start(tdc_start)
  );
  ckfp_far_model u_far (
    .hclk(hclk), .hs_osc_en(hs_osc_en), .meas_start(meas_start),
    .ref_clk_in(ref_clk_in), .hs_clk_in(hs_clk_in),
    .meas_done(meas_done)
  );

  // --------------
  // Helpers
  // --------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One single transfer; caller enters just after an edge
  task automatic ahb_go(input logic [7:0] a, input logic wr,
                        input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic ahb_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    ahb_go(a, 1'b0, 32'h0);
  endtask

  // One edge first: a stale flag is released only at the command edge
  task automatic wait_irq(input int lim);
    @(posedge hclk);
    for (k = 0; k < lim && irq_n !== 1'b0; k++) @(posedge hclk);
    chk({31'h0, irq_n}, 32'h0);
  endtask

  // Reference rises between two rises of a test pin
  task automatic pin_period(input logic two, input int e);
    logic p;
    logic q;
    n0 = 0;
    p = 1'b1;
    for (k = 0; k < 8000; k++) begin
      @(posedge hclk);
      q = two ? test_out_pin2 : test_out_pin1;
      if (q === 1'b1 && p === 1'b0) begin
        if (n0 != 0) break;
        n0 = n_ref;
      end
      p = q;
    end
    chk(32'(n_ref - n0), 32'(e));
  endtask

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // --------------
  // Clock, monitors and watchdog
  // --------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_dp && hready === 1'b1 && exp_q.size() > 0)
      chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
    if (hready === 1'b1) rd_dp <= hsel && htrans[1] && !hwrite;
  end

  always @(posedge ref_clk_in) n_ref++;
  always @(posedge fire_out_a) n_a++;
  always @(posedge hclk) begin
    if (tdc_start === 1'b1) n_tdc++;
    if (cmp_on && fire_out_a === 1'b1) chk({31'h0, fire_out_b}, 32'h0);
  end

  // Whole run needs about 1.2 ms
  initial begin
    #5_000_000;
    mismatches++;
    end_sim();
  end

  // --------------
  // Main sequence
  // --------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_dp = 1'b0;
    cmp_on = 1'b0;
    seed = 32'h6538db7f;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, hs_osc_en}, 32'h1);
    ahb_rd(`CKFP_OFS_CLK_CFG, 32'h1, 32'h3ff);
    ahb_rd(`CKFP_OFS_FIRE_CFG, 32'h10000, 32'he03f037f);
    ahb_rd(8'h20, 32'h0, 32'hffffffff);
    seed = xs(seed);
    ahb_go(`CKFP_OFS_FIRE_CFG, 1'b1, seed);
    ahb_rd(`CKFP_OFS_FIRE_CFG, seed, 32'he03f037f);
    // Pin 1 carries the reference, pin 2 the reference over eight
    ahb_go(`CKFP_OFS_CLK_CFG, 1'b1, 32'hf1);
    pin_period(1'b0, 1);
    pin_period(1'b1, 8);
    // Every measurement command, codes 1 to 5, with the oscillator always on
    for (c = 1; c <= 5; c++) begin
      ahb_go(`CKFP_OFS_CMD, 1'b1, 32'(c));
      wait_irq(4000);
      ahb_rd(`CKFP_OFS_CMD, 32'(c), 32'h7);
      chk({31'h0, hs_osc_en}, 32'h1);
    end
    ahb_rd(`CKFP_OFS_CALIB, 32'h03d00000, 32'hfffe0000);
    // Gated oscillator with the shortest settling delay
    ahb_go(`CKFP_OFS_CLK_CFG, 1'b1, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, hs_osc_en}, 32'h0);
    n0 = n_ref;
    ahb_go(`CKFP_OFS_CMD, 1'b1, {29'h0, `CKFP_CMD_TEMP});
    for (k = 0; k < 8000 && meas_start !== 1'b1; k++) @(posedge hclk);
    chk(32'(n_ref - n0), 32'h10);
    wait_irq(400);
    @(posedge hclk);
    chk({31'h0, hs_osc_en}, 32'h0);
    ahb_go(`CKFP_OFS_CLK_CFG, 1'b1, 32'h0);
    ahb_go(`CKFP_OFS_CMD, 1'b1, {29'h0, `CKFP_CMD_FLIGHT});
    wait_irq(400);
    chk({31'h0, hs_osc_en}, 32'h0);
    // Fire bursts: complement with tdc start, a only, disabled
    seed = xs(seed);
    ahb_go(`CKFP_OFS_CLK_CFG, 1'b1, {23'h0, seed[0], 8'h01});
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      cnt = (i == 2) ? 32'h0 : {29'h0, seed[2:0]} % 32'h7 + 32'h1;
      ahb_go(`CKFP_OFS_FIRE_CFG, 1'b1,
             (i == 1 ? 32'h40030000 : 32'he0030300) | cnt);
      n_a = 0;
      n_tdc = 0;
      cmp_on <= (i == 0);
      ahb_go(`CKFP_OFS_CMD, 1'b1, {29'h0, `CKFP_CMD_FIRE});
      repeat (300) @(posedge hclk);
      cmp_on <= 1'b0;
      chk(32'(n_a), cnt);
      chk(32'(n_tdc), {31'h0, i == 0});
      chk({30'h0, fire_out_a_oe_n, fire_out_b_oe_n},
          i == 1 ? 32'h3 : 32'h0);
    end
    end_sim();
  end
endmodule // ckfp_clock_ctrl_test
